/* File: design/bcc_cfg.svh */
// Brake chopper control: widths, reset values and timing counts.
// Assumes inclusion by the package and the design module only.
`ifndef BCC_CFG_SVH
`define BCC_CFG_SVH
`define BCC_VOLT_W 16
`define BCC_CLK_MHZ 250
`define BCC_ON_LIMIT_S 3
// Longest On interval in cycles, 3 s at 250 MHz
`define BCC_ON_LIMIT_CYC (`BCC_ON_LIMIT_S * `BCC_CLK_MHZ * 1000000)
`define BCC_CNT_W 32
`define BCC_THR_RST 16'h0000
`endif

/* File: design/bcc_pkg.sv */
// Brake chopper control types.
// Assumes bcc_cfg.svh is on the include path.
`include "bcc_cfg.svh"
package bcc_pkg;
    typedef enum logic [1:0] {BCC_IDLE, BCC_ON, BCC_FAULT} bcc_state_t;
    // Threshold pair loaded by configuration
    typedef struct packed {
        logic [`BCC_VOLT_W-1:0] engage;
        logic [`BCC_VOLT_W-1:0] release_;
    } bcc_thr_t;
    // Fault indications
    typedef struct packed {
        logic onTimeout;
        logic shuntOverpower;
    } bcc_fault_t;
endpackage : bcc_pkg

/* File: design/bcc_brake_chopper.sv */
// Brake chopper control: hysteresis switch of the braking resistor,
// On interval timing and fault latching.
// Assumes bus voltage samples and resistor continuity are synchronous
// to mclk and in the same units as the thresholds.
`timescale 1ns/100ps
`include "bcc_cfg.svh"
module bcc_brake_chopper #(
    parameter int VOLT_W = `BCC_VOLT_W,
    parameter logic [`BCC_CNT_W-1:0] ON_LIMIT_CYC = `BCC_ON_LIMIT_CYC
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [VOLT_W-1:0] busVolt,
    input wire bcc_pkg::bcc_thr_t thrIn,
    input wire logic thrLoad,
    input wire logic resistorPresent,
    input wire logic faultClear,
    output logic resistorOn,
    output logic motorEnable,
    output bcc_pkg::bcc_fault_t fault,
    output logic thrValid,
    output logic [`BCC_CNT_W-1:0] lastOnCycles
);

    // Stored threshold pair and its validity flag
    bcc_pkg::bcc_thr_t thr_r;
    bcc_pkg::bcc_thr_t thr_nxt;
    logic valid_r;
    logic valid_nxt;

    // Switching state of the resistor
    bcc_pkg::bcc_state_t state_r;
    bcc_pkg::bcc_state_t state_nxt;

    // Sticky fault indications
    bcc_pkg::bcc_fault_t fault_r;
    bcc_pkg::bcc_fault_t fault_nxt;

    // On interval timing: running count and last finished length
    logic [`BCC_CNT_W-1:0] onCnt_r;
    logic [`BCC_CNT_W-1:0] onCnt_nxt;
    logic [`BCC_CNT_W-1:0] last_r;
    logic [`BCC_CNT_W-1:0] last_nxt;

    // Decoded conditions shared by all groups
    logic thrOk;
    logic inIdle;
    logic inOn;
    logic inFault;
    logic engageHit;
    logic pathOpen;
    logic overLimit;
    logic goFault;
    logic reloadHit;
    logic endNormal;

    // Validity of the incoming pair; equal thresholds give no hysteresis
    assign thrOk = thrIn.release_ < thrIn.engage;

    // State decode, kept apart so every group reads the same view
    assign inIdle = (state_r == bcc_pkg::BCC_IDLE);
    assign inOn = (state_r == bcc_pkg::BCC_ON);
    assign inFault = (state_r == bcc_pkg::BCC_FAULT);

    // Engage only on a valid stored pair and not during a reload,
    // so a half-written pair can never close the switch
    assign engageHit = inIdle && valid_r && !thrLoad
        && (busVolt >= thr_r.engage);

    // Open path mid-brake: thermal switch tripped; highest priority
    assign pathOpen = inOn && !resistorPresent;

    // Interval too long; only counted while the path is intact
    assign overLimit = inOn && !pathOpen
        && (onCnt_r >= ON_LIMIT_CYC);

    // Either fault leaves the On state for the latched fault state
    assign goFault = pathOpen || overLimit;

    // Reload or invalid pair mid-brake opens the switch as a safe default
    assign reloadHit = inOn && !goFault && (!valid_r || thrLoad);

    // Normal end of an interval at the release threshold
    assign endNormal = inOn && !goFault && !reloadHit
        && (busVolt <= thr_r.release_);

    // Threshold group: next pair and validity
    always_comb begin
        thr_nxt = thr_r;
        valid_nxt = valid_r;
        if (thrLoad) begin
            thr_nxt = thrIn;
            valid_nxt = thrOk;
        end
    end

    // Threshold group: registers; zero pair is invalid after reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            thr_r <= {`BCC_THR_RST, `BCC_THR_RST};
            valid_r <= 1'b0;
        end else begin
            thr_r <= thr_nxt;
            valid_r <= valid_nxt;
        end
    end

    // State group: hysteresis switching with fault latch
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            bcc_pkg::BCC_IDLE: begin
                if (engageHit) begin
                    state_nxt = bcc_pkg::BCC_ON;
                end
            end
            bcc_pkg::BCC_ON: begin
                if (goFault) begin
                    state_nxt = bcc_pkg::BCC_FAULT;
                end else if (reloadHit || endNormal) begin
                    // Back to idle; may re-engage on the next edge
                    state_nxt = bcc_pkg::BCC_IDLE;
                end
            end
            bcc_pkg::BCC_FAULT: begin
                // Latched until explicitly cleared; switch stays open
                if (faultClear) begin
                    state_nxt = bcc_pkg::BCC_IDLE;
                end
            end
            // Unused code of the two-bit state falls back to idle
            default: state_nxt = bcc_pkg::BCC_IDLE;
        endcase
    end

    // State group: register
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= bcc_pkg::BCC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Fault group: clear only in fault state, set wins over clear
    always_comb begin
        fault_nxt = fault_r;
        if (inFault && faultClear) begin
            fault_nxt = '0;
        end
        if (pathOpen) begin
            fault_nxt.shuntOverpower = 1'b1;
        end
        if (overLimit) begin
            fault_nxt.onTimeout = 1'b1;
        end
    end

    // Fault group: register
    always_ff @(posedge mclk) begin
        if (srst) begin
            fault_r <= '0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    // Timing group: count On cycles, record length on a normal end;
    // a cut interval (fault or reload) leaves the record untouched
    always_comb begin
        onCnt_nxt = onCnt_r;
        last_nxt = last_r;
        if (inOn) begin
            onCnt_nxt = onCnt_r + 32'h0000_0001;
        end else if (inIdle) begin
            onCnt_nxt = '0;
        end
        if (endNormal) begin
            last_nxt = onCnt_nxt;
        end
    end

    // Timing group: registers; the limit stops the count long
    // before it could wrap
    always_ff @(posedge mclk) begin
        if (srst) begin
            onCnt_r <= '0;
            last_r <= '0;
        end else begin
            onCnt_r <= onCnt_nxt;
            last_r <= last_nxt;
        end
    end

    // Outputs straight from state flops
    assign resistorOn = (state_r == bcc_pkg::BCC_ON);
    assign motorEnable = (state_r != bcc_pkg::BCC_FAULT);
    assign fault = fault_r;
    assign thrValid = valid_r;
    assign lastOnCycles = last_r;

endmodule : bcc_brake_chopper

/* File: sim/bcc_chk_properties.sv */
// Switch and fault relations of the brake chopper.
// Assumes a bind onto bcc_brake_chopper, one mclk domain.
`timescale 1ns/100ps
module bcc_chk_properties (
    input wire logic mclk,
    input wire logic srst,
    input wire logic resistorPresent,
    input wire logic resistorOn,
    input wire logic motorEnable,
    input wire logic thrValid,
    input wire logic thrLoad,
    input wire logic faultClear,
    input wire logic [31:0] lastOnCycles,
    input wire bcc_pkg::bcc_fault_t fault
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    property p_arm; !thrValid |=> !$rose(resistorOn); endproperty
    a_arm: assert property (p_arm) else $error("unarmed engage");
    property p_sh; resistorOn && !resistorPresent |=> fault[0]; endproperty
    a_sh: assert property (p_sh) else $error("no shunt fault");
    property p_off; |fault |-> !motorEnable && !resistorOn; endproperty
    a_off: assert property (p_off) else $error("drive on in fault");
    property p_clr; |fault && faultClear |=> !(|fault) && motorEnable;
    endproperty
    a_clr: assert property (p_clr) else $error("fault not cleared");
    property p_rld; resistorOn && thrLoad |=> !resistorOn; endproperty
    a_rld: assert property (p_rld) else $error("reload kept on");
    property p_eng;
        $rose(resistorOn) |-> $past(thrValid) && !$past(thrLoad);
    endproperty
    a_eng: assert property (p_eng) else $error("bad engage");
    property p_last; $changed(lastOnCycles) |-> $fell(resistorOn);
    endproperty
    a_last: assert property (p_last) else $error("stray length");
endmodule : bcc_chk_properties
bind bcc_brake_chopper bcc_chk_properties bcc_chk_properties_inst (.*);

/* File: sim/bcc_bus_model.sv */
// Far side: regen lifts the bus, a closed switch drains it.
// Assumes inputs change at the falling edge of mclk.
`timescale 1ns/100ps
module bcc_bus_model (input wire logic mclk, resistorOn, regen, stuck, cut,
    output logic [15:0] busVolt, output logic resistorPresent);
    initial busVolt = 16'h000C;
    // Stuck or open path stops the drain; a stuck switch keeps On running until its limit ends it
    always @(posedge mclk) begin
        if (resistorOn && !stuck && !cut) busVolt <= busVolt - 16'h0001;
        else if (regen && !resistorOn) busVolt <= busVolt + 16'h0001;
    end
    assign resistorPresent = !cut; // Thermal switch open
endmodule : bcc_bus_model

/* File: sim/tb_brake_chopper_control.sv */
// Bench: On timing, retrigger, time limit and shunt fault.
// Assumes bcc_bus_model at the far side and a 40 cycle limit.
`timescale 1ns/100ps
module tb_brake_chopper_control;
    logic mclk = 1'h0, srst = 1'h1, thrLoad = 1'h0, faultClear = 1'h0, rp;
    logic regen = 1'h0, stuck = 1'h0, cut = 1'h0, resistorOn, motorEnable;
    logic thrValid;
    logic [15:0] busVolt;
    logic [31:0] lastOnCycles;
    bcc_pkg::bcc_thr_t thrIn = '0;
    bcc_pkg::bcc_fault_t fault;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    bcc_brake_chopper #(.ON_LIMIT_CYC(32'h28)) bcc_brake_chopper_inst (.*,
        .resistorPresent(rp), .thrValid(thrValid));
    bcc_bus_model bcc_bus_model_inst (.*, .resistorPresent(rp));
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) if (++cyc == 600) close_out(1); // Hang guard
    task automatic chk(input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) n_mismatch++;
        if (s !== e) $display("[FAIL] %0t %h %h", $time, s, e);
    endtask : chk
    task automatic wt(input logic v); // Bounded wait on the switch
        for (int i = 0; i < 99 && resistorOn !== v; i++) @(negedge mclk);
    endtask : wt
    task automatic tReset; // Rest values; zero pair must stay refused
        chk(32'({resistorOn, motorEnable, fault, thrValid}), 32'h8);
        chk(lastOnCycles, 32'h0);
        repeat (3) @(negedge mclk);
        chk(32'({resistorOn, thrValid}), 32'h0);
        $display("tReset end");
    endtask : tReset
    task automatic tInval; // Reload mid-brake with a bad pair, then good
        {cut, faultClear} = 2'h1; @(negedge mclk) faultClear = 1'h0;
        wt(1'h1);
        {thrIn, thrLoad} = {16'hA, 16'h14, 1'h1};
        @(negedge mclk) thrLoad = 1'h0;
        repeat (4) @(negedge mclk);
        chk(32'({resistorOn, thrValid}), 32'h0);
        chk(lastOnCycles, 32'hC);
        {thrIn, thrLoad} = {16'h14, 16'hA, 1'h1};
        @(negedge mclk) thrLoad = 1'h0;
        wt(1'h1); chk(32'({resistorOn, thrValid}), 32'h3);
        $display("tInval end");
    endtask : tInval
    task automatic tOn;
        @(negedge mclk) {thrIn, thrLoad, regen} = {16'h14, 16'hA, 2'h3};
        @(negedge mclk) thrLoad = 1'h0;
        wt(1'h1); wt(1'h0);
        chk(lastOnCycles, 32'hC);
        chk(32'(busVolt), 32'h9);
        wt(1'h1); chk(32'(resistorOn), 32'h1);
        $display("tOn end");
    endtask : tOn
    task automatic tLim;
        stuck = 1'h1; wt(1'h0);
        chk(32'({fault, motorEnable}), 32'h4);
        {stuck, faultClear} = 2'h1; @(negedge mclk) faultClear = 1'h0;
        chk(32'({fault, motorEnable}), 32'h1);
        $display("tLim end");
    endtask : tLim
    task automatic tShunt;
        wt(1'h1); cut = 1'h1; @(negedge mclk);
        chk(32'({fault, motorEnable}), 32'h2);
        $display("tShunt end");
    endtask : tShunt
    task automatic close_out(input int to);
        n_mismatch += to;
        $display("mismatch %0d of %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // Thresholds stay zero through reset, so engage stays refused
    initial begin
        repeat (12) @(negedge mclk);
        srst = 1'h0;
        tReset(); tOn(); tLim(); tShunt(); tInval(); close_out(0);
    end
endmodule : tb_brake_chopper_control
